//--- hw/ppom_pkg.sv
// package: constants for the parallel pin owner mux
package ppom_pkg;
   // register index (word offsets on the plain register port)
   localparam logic [3:0] ADDR_UC_STATUS = 4'h0;
   localparam logic [3:0] ADDR_UC_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_UC_DATA = 4'h2;
   localparam logic [3:0] ADDR_OWNER_CFG = 4'h3;
   localparam logic [3:0] ADDR_SENSE_STAT = 4'h4;
   localparam logic [3:0] ADDR_HOST_DATA = 4'h5;
   localparam logic [3:0] ADDR_HOST_CONTROL = 4'h6;
   localparam logic [3:0] ADDR_HOST_STATUS = 4'h7;
   // device-mode field encodings
   localparam logic [1:0] MODE_PAR = 2'h0;
   localparam logic [1:0] MODE_FLOPPY_A = 2'h1;
   localparam logic [1:0] MODE_FLOPPY_B = 2'h2;
   localparam logic [1:0] MODE_IDLE = 2'h3;
   // owner config register fields
   localparam int CFG_HA_BIT = 0;
   localparam int CFG_SENSE_IE_BIT = 1;
   // sense status register fields
   localparam int SS_LEVEL_BIT = 0;
   localparam int SS_CHANGE_BIT = 1;
   // cable-not-connected read patterns (5 control bits, 8 status bits)
   localparam logic [7:0] CTRL_NO_CABLE = 8'h04;
   localparam logic [7:0] STAT_NO_CABLE = 8'h48;
   // reset values
   localparam logic [7:0] UC_CONTROL_RST = 8'h00;
   localparam logic [7:0] UC_DATA_RST = 8'h00;
   localparam logic [1:0] CFG_RST = 2'h0;
   // owners
   typedef enum logic [1:0] {OWN_UC, OWN_FLOPPY, OWN_PAR, OWN_NONE} ppom_owner_t;
endpackage

//--- hw/ppom_sync.sv
// module: two-flop synchroniser with edge detect on the synced level
`timescale 1ns/10ps
module ppom_sync (
   input wire logic ref_clk_i, // system clock
   input wire logic rstn_i, // async reset, active low
   input wire logic async_i, // pin level from outside
   output logic level_o, // synchronised level
   output logic edge_o // one-cycle pulse on either edge
);
   logic meta;
   logic sync;
   logic prev;

   // first flop only feeds the second
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= async_i;
         sync <= meta;
         prev <= sync;
      end
   end

   assign level_o = sync;
   assign edge_o = sync ^ prev;
endmodule

//--- hw/ppom_mux.sv
// module: ownership mux for the shared parallel-port pin group
//
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module ppom_mux #(
   parameter int DATA_W = 8, // data pin group width
   parameter int CTRL_W = 5 // control pin group width
) (
   input wire logic ref_clk_i, // system clock
   input wire logic rstn_i, // async reset, active low
   // microcontroller register port
   input wire logic [3:0] reg_addr_i, // register index
   input wire logic [7:0] reg_wdata_i, // write data
   input wire logic reg_wr_i, // write strobe
   input wire logic reg_rd_i, // read strobe
   output logic [7:0] reg_rdata_o, // read data, cycle after strobe
   // configuration from the logical devices
   input wire logic [1:0] device_mode_config_i, // device-mode field
   input wire logic floppy_activate_bit_i, // floppy activate
   input wire logic floppy_pwrdn_i, // floppy powered down
   input wire logic par_activate_i, // parallel port activate
   input wire logic par_pwrdn_i, // parallel port powered down
   input wire logic [1:0] floppy_mode_config_i, // drive-type bits, unused on pins
   input wire logic aux_power_good_i, // secondary supply power good
   // host parallel port logical device drive
   input wire logic [DATA_W-1:0] par_data_i, // data out
   input wire logic [DATA_W-1:0] par_data_oe_n_i, // data oe, low drives
   input wire logic [CTRL_W-1:0] par_ctrl_i, // control out
   input wire logic [CTRL_W-1:0] par_ctrl_oe_n_i, // control oe, low drives
   // host side reads while not owner
   input wire logic host_rd_data_i, // host reads data register
   input wire logic host_rd_ctrl_i, // host reads control register
   input wire logic host_rd_stat_i, // host reads status register
   input wire logic [7:0] host_wdata_i, // host data write value
   input wire logic host_wr_data_i, // host data write strobe
   output logic [7:0] host_rdata_o, // host read data when not owner
   output logic host_owns_o, // host parallel port owns the pins
   // floppy controller drive (open-drain sink outputs)
   input wire logic [DATA_W-1:0] fdc_data_i, // floppy values on data pins
   input wire logic [DATA_W-1:0] fdc_data_oe_n_i, // floppy oe on data pins
   input wire logic [CTRL_W-1:0] fdc_ctrl_i, // floppy values on control pins
   input wire logic [CTRL_W-1:0] fdc_ctrl_oe_n_i, // floppy oe on control pins
   // shared pins
   input wire logic [DATA_W-1:0] pin_data_i, // data pin levels
   output logic [DATA_W-1:0] pin_data_o, // data pin drive
   output logic [DATA_W-1:0] pin_data_oe_n_o, // data oe, low drives
   input wire logic [CTRL_W-1:0] pin_ctrl_i, // control pin levels
   output logic [CTRL_W-1:0] pin_ctrl_o, // control pin drive
   output logic [CTRL_W-1:0] pin_ctrl_oe_n_o, // control oe, low drives
   input wire logic [4:0] pin_stat_i, // status input pins
   input wire logic cable_type_sense_i, // cable sense pin
   output logic sense_irq_o // microcontroller interrupt, level
);
   logic [7:0] uc_ctrl;
   logic [7:0] uc_data;
   logic host_access_select;
   logic sense_ie;
   logic sense_chg;
   logic sense_lvl;
   logic sense_edge;
   logic [7:0] host_last_data;
   logic [7:0] next_rdata;
   logic [4:0] stat_meta;
   logic [4:0] stat_sync;
   logic [DATA_W-1:0] pdat_meta;
   logic [DATA_W-1:0] pdat_sync;
   logic [CTRL_W-1:0] pctl_meta;
   logic [CTRL_W-1:0] pctl_sync;
   ppom_pkg::ppom_owner_t owner;
   logic owner_on;

   // sense pin crossing and edge detection
   ppom_sync u_sense (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .async_i(cable_type_sense_i),
      .level_o(sense_lvl),
      .edge_o(sense_edge)
   );

   // all pin levels are asynchronous: two flops, so reads lag the pins by two cycles
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         stat_meta <= '0;
         stat_sync <= '0;
         pdat_meta <= '0;
         pdat_sync <= '0;
         pctl_meta <= '0;
         pctl_sync <= '0;
      end else begin
         stat_meta <= pin_stat_i;
         stat_sync <= stat_meta;
         pdat_meta <= pin_data_i;
         pdat_sync <= pdat_meta;
         pctl_meta <= pin_ctrl_i;
         pctl_sync <= pctl_meta;
      end
   end

   // microcontroller control and data registers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         uc_ctrl <= ppom_pkg::UC_CONTROL_RST;
         uc_data <= ppom_pkg::UC_DATA_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ppom_pkg::ADDR_UC_CONTROL) begin
            uc_ctrl <= reg_wdata_i;
         end
         if (reg_addr_i == ppom_pkg::ADDR_UC_DATA) begin
            uc_data <= reg_wdata_i;
         end
      end
   end

   // owner config: firmware sets host_access_select and sense irq enable
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_access_select <= ppom_pkg::CFG_RST[ppom_pkg::CFG_HA_BIT];
         sense_ie <= ppom_pkg::CFG_RST[ppom_pkg::CFG_SENSE_IE_BIT];
      end else if (reg_wr_i && reg_addr_i == ppom_pkg::ADDR_OWNER_CFG) begin
         host_access_select <= reg_wdata_i[ppom_pkg::CFG_HA_BIT];
         sense_ie <= reg_wdata_i[ppom_pkg::CFG_SENSE_IE_BIT];
      end
   end

   // sticky change flag, write one to clear; a new edge beats the clear
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sense_chg <= 1'b0;
      end else if (sense_edge) begin
         sense_chg <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == ppom_pkg::ADDR_SENSE_STAT
                   && reg_wdata_i[ppom_pkg::SS_CHANGE_BIT]) begin
         sense_chg <= 1'b0;
      end
   end

   assign sense_irq_o = sense_chg & sense_ie; // firmware then raises host event

   // owner select; drive-type bits deliberately not an input here
   always_comb begin
      owner = ppom_pkg::OWN_NONE;
      owner_on = 1'b0;
      if (!host_access_select) begin
         owner = ppom_pkg::OWN_UC;
         owner_on = aux_power_good_i;
      end else if (device_mode_config_i == ppom_pkg::MODE_FLOPPY_A
                   || device_mode_config_i == ppom_pkg::MODE_FLOPPY_B) begin
         owner = ppom_pkg::OWN_FLOPPY;
         owner_on = floppy_activate_bit_i & ~floppy_pwrdn_i;
      end else if (device_mode_config_i == ppom_pkg::MODE_PAR) begin
         owner = ppom_pkg::OWN_PAR;
         owner_on = par_activate_i & ~par_pwrdn_i;
      end
   end

   // pin drive: inactive source leaves pins at high impedance
   always_comb begin
      pin_data_o = '0;
      pin_data_oe_n_o = '1;
      pin_ctrl_o = '0;
      pin_ctrl_oe_n_o = '1;
      if (owner_on) begin
         unique case (owner)
            ppom_pkg::OWN_UC: begin
               pin_data_o = uc_data[DATA_W-1:0];
               pin_data_oe_n_o = '0;
               pin_ctrl_o = uc_ctrl[CTRL_W-1:0];
               pin_ctrl_oe_n_o = '0;
            end
            ppom_pkg::OWN_FLOPPY: begin
               pin_data_o = fdc_data_i;
               pin_data_oe_n_o = fdc_data_oe_n_i;
               pin_ctrl_o = fdc_ctrl_i;
               pin_ctrl_oe_n_o = fdc_ctrl_oe_n_i;
            end
            ppom_pkg::OWN_PAR: begin
               pin_data_o = par_data_i;
               pin_data_oe_n_o = par_data_oe_n_i;
               pin_ctrl_o = par_ctrl_i;
               pin_ctrl_oe_n_o = par_ctrl_oe_n_i;
            end
            ppom_pkg::OWN_NONE: begin
               pin_data_o = '0;
            end
         endcase
      end
   end

   assign host_owns_o = (owner == ppom_pkg::OWN_PAR);

   // host data write is remembered for reads while not the owner
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_last_data <= ppom_pkg::UC_DATA_RST;
      end else if (host_wr_data_i) begin
         host_last_data <= host_wdata_i;
      end
   end

   // host read answers; registered so they stand one cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         host_rdata_o <= '0;
      end else if (host_rd_data_i) begin
         host_rdata_o <= host_last_data;
      end else if (host_rd_ctrl_i) begin
         host_rdata_o <= ppom_pkg::CTRL_NO_CABLE;
      end else if (host_rd_stat_i) begin
         host_rdata_o <= ppom_pkg::STAT_NO_CABLE;
      end else begin
         host_rdata_o <= '0;
      end
   end

   // microcontroller read mux
   always_comb begin
      next_rdata = '0;
      unique case (reg_addr_i)
         ppom_pkg::ADDR_UC_STATUS: next_rdata = {3'h0, stat_sync};
         ppom_pkg::ADDR_UC_CONTROL: next_rdata = uc_ctrl;
         ppom_pkg::ADDR_UC_DATA: next_rdata = uc_data;
         ppom_pkg::ADDR_OWNER_CFG: next_rdata = {6'h00, sense_ie, host_access_select};
         ppom_pkg::ADDR_SENSE_STAT: next_rdata = {6'h00, sense_chg, sense_lvl};
         ppom_pkg::ADDR_HOST_DATA: next_rdata = host_last_data;
         ppom_pkg::ADDR_HOST_CONTROL: next_rdata = {3'h0, pctl_sync};
         ppom_pkg::ADDR_HOST_STATUS: next_rdata = pdat_sync[7:0];
         default: next_rdata = '0;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= '0;
      end else begin
         reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
      end
   end
endmodule

//--- sim/ppom_cable.sv
// partner: attached cable with pulled-up lines and the type sense pin
`timescale 1ns/10ps
module ppom_cable (
   input wire logic floppy_i, // floppy cable plugged
   input wire logic [7:0] data_i, // data pin drive
   input wire logic [7:0] data_oe_n_i, // data oe, low drives
   input wire logic [4:0] ctrl_i, // control pin drive
   input wire logic [4:0] ctrl_oe_n_i, // control oe, low drives
   output logic [7:0] data_lvl_o, // data pin levels
   output logic [4:0] ctrl_lvl_o, // control pin levels
   output logic [4:0] stat_o, // status pin levels
   output logic sense_o // cable type sense
);
   // released lines float up through the cable pull-ups
   assign data_lvl_o = data_i | data_oe_n_i;
   assign ctrl_lvl_o = ctrl_i | ctrl_oe_n_i;
   assign stat_o = floppy_i ? 5'h1F : 5'h18;
   assign sense_o = floppy_i; // high asks for floppy
endmodule

//--- sim/ppom_mux_asserts.sv
// checker: pin ownership and sense interrupt properties
`timescale 1ns/10ps
module ppom_mux_asserts #(
   parameter int DATA_W = 8, // data pins
   parameter int CTRL_W = 5 // control pins
) (
   input wire logic ref_clk_i, // clock
   input wire logic rstn_i, // reset
   input wire logic [3:0] reg_addr_i, // index
   input wire logic [7:0] reg_wdata_i, // wdata
   input wire logic reg_wr_i, // write
   input wire logic aux_power_good_i, // power good
   input wire logic [1:0] device_mode_config_i, // mode
   input wire logic floppy_activate_bit_i, // fdc on
   input wire logic floppy_pwrdn_i, // fdc down
   input wire logic par_activate_i, // par on
   input wire logic par_pwrdn_i, // par down
   input wire logic [DATA_W-1:0] par_data_i, // par data
   input wire logic [DATA_W-1:0] par_data_oe_n_i, // par oe
   input wire logic [DATA_W-1:0] fdc_data_i, // fdc data
   input wire logic [DATA_W-1:0] fdc_data_oe_n_i, // fdc oe
   input wire logic [DATA_W-1:0] pin_data_o, // pins
   input wire logic [DATA_W-1:0] pin_data_oe_n_o, // pin oe
   input wire logic [CTRL_W-1:0] pin_ctrl_o, // ctrl pins
   input wire logic [CTRL_W-1:0] pin_ctrl_oe_n_o, // ctrl oe
   input wire logic cable_type_sense_i, // sense
   input wire logic sense_irq_o // irq
);
   logic ha, ie;
   logic [7:0] ud, uc;
   // 01 and 10 both pick floppy, so the xor of the field marks it
   wire fon = ha && ^device_mode_config_i && floppy_activate_bit_i && !floppy_pwrdn_i;
   wire pon = ha && device_mode_config_i == ppom_pkg::MODE_PAR && par_activate_i && !par_pwrdn_i;
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   // mirror of owner cfg and uc registers
   always_ff @(posedge ref_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         {ie, ha} <= ppom_pkg::CFG_RST;
         ud <= ppom_pkg::UC_DATA_RST;
         uc <= ppom_pkg::UC_CONTROL_RST;
      end else if (reg_wr_i) begin
         if (reg_addr_i == ppom_pkg::ADDR_OWNER_CFG) {ie, ha} <= reg_wdata_i[1:0];
         if (reg_addr_i == ppom_pkg::ADDR_UC_DATA) ud <= reg_wdata_i;
         if (reg_addr_i == ppom_pkg::ADDR_UC_CONTROL) uc <= reg_wdata_i;
      end
   end
   AST_UC_OE: assert property (!ha && aux_power_good_i |->
      pin_data_oe_n_o == '0 && pin_ctrl_oe_n_o == '0) else $error("uc pins not driven");
   AST_UC_OFF: assert property (!ha && !aux_power_good_i |->
      &pin_data_oe_n_o && &pin_ctrl_oe_n_o) else $error("uc pins not released");
   AST_UC_DATA: assert property (!ha && aux_power_good_i |->
      pin_data_o == ud[DATA_W-1:0] && pin_ctrl_o == uc[CTRL_W-1:0]) else $error("uc value");
   AST_FDC_ON: assert property (fon |-> pin_data_o == fdc_data_i &&
      pin_data_oe_n_o == fdc_data_oe_n_i) else $error("floppy not on pins");
   AST_PAR_ON: assert property (pon |-> pin_data_o == par_data_i &&
      pin_data_oe_n_o == par_data_oe_n_i) else $error("par not on pins");
   AST_SRC_OFF: assert property (ha && !fon && !pon |->
      &pin_data_oe_n_o && &pin_ctrl_oe_n_o) else $error("inactive source drives");
   AST_IRQ_SET: assert property (ie && $changed(cable_type_sense_i) |->
      ##[1:4] sense_irq_o) else $error("sense change lost");
   AST_IRQ_MASK: assert property (!ie |-> !sense_irq_o) else $error("masked irq");
endmodule
bind ppom_mux ppom_mux_asserts #(.DATA_W(DATA_W), .CTRL_W(CTRL_W)) u_chk (.*);

//--- sim/ppom_mux_test.sv
// testbench: owner mux scenarios against a cable model
`timescale 1ns/10ps
module ppom_mux_test;
   logic clk, rstn, wr, rd, pg, fa, fp, pa, pp, hrd, hrc, hrs, hwr, plug, own, irq, sns;
   logic [3:0] addr;
   logic [7:0] wd, hwd, pd, pdo, fd, fdo, rdat, hrdat, dl, po, poe;
   logic [1:0] mode, fmc;
   logic [4:0] pc, pco, fc, fco, cl, st, co, coe;
   int num_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   ppom_mux uut (.ref_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wd),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .device_mode_config_i(mode),
      .floppy_activate_bit_i(fa), .floppy_pwrdn_i(fp), .par_activate_i(pa),
      .par_pwrdn_i(pp), .floppy_mode_config_i(fmc), .aux_power_good_i(pg),
      .par_data_i(pd), .par_data_oe_n_i(pdo), .par_ctrl_i(pc), .par_ctrl_oe_n_i(pco),
      .host_rd_data_i(hrd), .host_rd_ctrl_i(hrc), .host_rd_stat_i(hrs),
      .host_wdata_i(hwd), .host_wr_data_i(hwr), .host_rdata_o(hrdat), .host_owns_o(own),
      .fdc_data_i(fd), .fdc_data_oe_n_i(fdo), .fdc_ctrl_i(fc), .fdc_ctrl_oe_n_i(fco),
      .pin_data_i(dl), .pin_data_o(po), .pin_data_oe_n_o(poe), .pin_ctrl_i(cl),
      .pin_ctrl_o(co), .pin_ctrl_oe_n_o(coe), .pin_stat_i(st),
      .cable_type_sense_i(sns), .sense_irq_o(irq));
   ppom_cable cab (.floppy_i(plug), .data_i(po), .data_oe_n_i(poe), .ctrl_i(co),
      .ctrl_oe_n_i(coe), .data_lvl_o(dl), .ctrl_lvl_o(cl), .stat_o(st), .sense_o(sns));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic bw(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      {addr, wd, wr} <= {a, d, 1'h1};
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic br(input logic [3:0] a, input logic [7:0] e, input string m);
      @(posedge clk);
      {addr, rd} <= {a, 1'h1};
      @(posedge clk);
      rd <= 1'h0;
      #1 chk(rdat, e, m);
   endtask
   // pins are combinational, so one settled cycle is enough
   task automatic pk(input logic [7:0] d, e, input logic [4:0] c, ce, input string m);
      @(posedge clk);
      #1 chk(po, d, m);
      chk(poe, e, m);
      chk({3'h0, co}, {3'h0, c}, m);
      chk({3'h0, coe}, {3'h0, ce}, m);
   endtask
   // bounded wait: change flag lands a few edges after the pin moves
   task automatic wirq(input logic e);
      repeat (6) @(posedge clk);
      #1 chk({7'h0, irq}, {7'h0, e}, "irq");
   endtask
   task automatic t_uc;
      pk(8'h00, 8'h00, 5'h00, 5'h00, "rst pins");
      br(ppom_pkg::ADDR_OWNER_CFG, 8'h00, "cfg rst");
      bw(ppom_pkg::ADDR_UC_DATA, 8'hA5);
      bw(ppom_pkg::ADDR_UC_CONTROL, 8'h1F);
      bw(ppom_pkg::ADDR_UC_STATUS, 8'hFF);
      {pa, pp} <= 2'h2;
      pk(8'hA5, 8'h00, 5'h1F, 5'h00, "uc own");
      br(ppom_pkg::ADDR_UC_DATA, 8'hA5, "uc data");
      br(ppom_pkg::ADDR_UC_STATUS, {3'h0, st}, "uc stat");
      br(4'h9, 8'h00, "unmapped");
      @(posedge clk);
      pg <= 1'h0;
      pk(8'h00, 8'hFF, 5'h00, 5'h1F, "no power");
      @(posedge clk);
      pg <= 1'h1;
      $display("test uc done");
   endtask
   task automatic t_host;
      @(posedge clk);
      {hwd, hwr} <= {8'h3C, 1'h1};
      @(posedge clk);
      {hwr, hrd} <= 2'h1;
      @(posedge clk);
      {hrd, hrc} <= 2'h1;
      #1 chk(hrdat, 8'h3C, "host data");
      @(posedge clk);
      {hrc, hrs} <= 2'h1;
      #1 chk(hrdat, ppom_pkg::CTRL_NO_CABLE, "host ctrl");
      @(posedge clk);
      hrs <= 1'h0;
      #1 chk(hrdat, ppom_pkg::STAT_NO_CABLE, "host stat");
      $display("test host done");
   endtask
   task automatic t_mode;
      bw(ppom_pkg::ADDR_OWNER_CFG, 8'h01);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         // upper entries force a floppy mode over the parallel port state
         {mode, fa, fp, pa, pp} <= i[4] ? {4'h6, ~i[1], i[0]} : {i[3:2], i[1:0], ~i[1], i[0]};
         fmc <= i[1:0] ^ i[4:3]; // drive-type bits must not matter
         if (i[4] || (^i[3:2] && i[1:0] == 2'h2)) pk(fd, fdo, fc, fco, "fdc");
         else if (i[3:0] == 4'h0) pk(pd, pdo, pc, pco, "par");
         else pk(8'h00, 8'hFF, 5'h00, 5'h1F, "off");
      end
      $display("test mode done");
   endtask
   task automatic t_sense;
      bw(ppom_pkg::ADDR_OWNER_CFG, 8'h02);
      plug <= 1'h1;
      wirq(1'h1);
      br(ppom_pkg::ADDR_SENSE_STAT, 8'h03, "floppy req");
      bw(ppom_pkg::ADDR_SENSE_STAT, 8'h02);
      {mode, fa, fp} <= 4'h6;
      bw(ppom_pkg::ADDR_OWNER_CFG, 8'h03);
      pk(fd, fdo, fc, fco, "to fdc");
      chk({7'h0, irq}, 8'h00, "irq clear");
      @(posedge clk);
      plug <= 1'h0;
      wirq(1'h1);
      br(ppom_pkg::ADDR_SENSE_STAT, 8'h02, "par req");
      @(posedge clk);
      {mode, pa, pp} <= 4'h2;
      pk(pd, pdo, pc, pco, "to par");
      chk({7'h0, own}, 8'h01, "host owns");
      bw(ppom_pkg::ADDR_OWNER_CFG, 8'h00);
      pk(8'hA5, 8'h00, 5'h1F, 5'h00, "to uc");
      br(ppom_pkg::ADDR_HOST_STATUS, 8'hA5, "data pins");
      br(ppom_pkg::ADDR_HOST_CONTROL, 8'h1F, "ctrl pins");
      br(ppom_pkg::ADDR_HOST_DATA, 8'h3C, "host last");
      @(posedge clk);
      plug <= 1'h1;
      wirq(1'h0);
      $display("test sense done");
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   // hang guard well beyond the roughly 120 cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         summarize();
      end
   end
   initial begin
      {rstn, wr, rd, hrd, hrc, hrs, hwr, plug, fa, fp, pa, pp, addr, wd, hwd, mode, fmc} = '0;
      pg = 1'h1;
      {pd, pdo, fd, fdo, pc, pco, fc, fco} = {32'hC3005A0F, 20'h0A0F3};
      repeat (10) @(posedge clk);
      rstn <= 1'h1;
      t_uc();
      t_host();
      t_mode();
      t_sense();
      summarize();
   end
endmodule
